/* hw/cycle_timer.sv */
// down counter that pulses done when a loaded count expires
// assumes the owner loads it only when idle
`timescale 1ns/100ps
module cycle_timer (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // control
  input  wire logic        i_load,
  input  wire logic [15:0] i_count,
  // status
  output logic             o_done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        done;
  } tmr_t;
  tmr_t st_r;
  tmr_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (i_load) begin
      st_nxt.cnt = i_count;
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      if (st_r.cnt <= 16'h0001) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.done;
endmodule

/* hw/reconfig_hs.sv */
// fabric-side handshake of the transceiver reconfiguration controller
// assumes fabric requests are synchronous to i_ref_clk
`timescale 1ns/100ps
`include "reconfig_hs_defs.svh"
module reconfig_hs
  import reconfig_hs_pkg::*;
#(
  parameter int OC_CYCLES = `OC_CYCLES
) (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  // configuration
  input  wire logic                   i_cont_write_en,
  input  wire logic [`LAT_W-1:0]      i_read_latency,
  input  wire logic [`WORD_CNT_W-1:0] i_word_count,
  input  wire logic                   i_analog_mode,
  input  wire logic                   i_analog_port_sel,
  input  wire logic                   i_read_port_en,
  input  wire logic                   i_err_check_en,
  // fabric requests
  input  wire logic                   i_write_all,
  input  wire logic                   i_read,
  input  wire logic [`DATA_W-1:0]     i_xcvr_rdata,
  // status
  output logic                        o_busy,
  output logic                        o_read_valid,
  output logic [`DATA_W-1:0]          o_read_data,
  output logic                        o_error,
  output logic                        o_word_strobe
);
  // ==========================================================
  // state
  typedef struct packed {
    hs_state_t              state;
    logic                   busy;
    logic                   valid;
    logic [`DATA_W-1:0]     rdata;
    logic                   err;
    logic [1:0]             err_cnt;
    logic [`WORD_CNT_W-1:0] words;
    logic [`LAT_W+2:0]      wait_cnt;
    logic                   strobe;
    logic                   oc_load;
  } hs_t;
  hs_t st_r;
  hs_t st_nxt;
  logic oc_done;

  function automatic logic read_ok(input logic am, input logic ps);
    read_ok = am & ps;
  endfunction

  // ==========================================================
  // offset cancellation timer
  cycle_timer u_oc_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (st_r.oc_load),
    .i_count   (16'(OC_CYCLES)),
    .o_done    (oc_done)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.strobe  = 1'b0;
    st_nxt.valid   = 1'b0;
    st_nxt.oc_load = 1'b0;
    st_nxt.err     = 1'b0;
    unique case (st_r.state)
      ST_POWERUP: begin
        st_nxt.busy    = 1'b1;
        st_nxt.oc_load = 1'b1;
        st_nxt.state   = ST_OFFSET;
      end
      ST_OFFSET: begin
        if (oc_done) begin
          st_nxt.busy  = 1'b0;
          st_nxt.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_write_all) begin
          if (i_analog_mode) begin
            st_nxt.words = `WORD_CNT_W'(1);
          end else if (i_cont_write_en) begin
            st_nxt.words = i_word_count;
          end else begin
            st_nxt.words = `WORD_CNT_W'(1);
          end
          st_nxt.wait_cnt = (i_cont_write_en && !i_analog_mode)
            ? ((`LAT_W+3)'(i_read_latency) + (`LAT_W+3)'(`XACT_CYCLES))
            : (`LAT_W+3)'(`XACT_CYCLES);
          st_nxt.busy  = 1'b1;
          st_nxt.state = ST_WRITE;
        end else if (i_read) begin
          if (read_ok(i_analog_mode, i_analog_port_sel)) begin
            st_nxt.wait_cnt = (`LAT_W+3)'(`XACT_CYCLES);
            st_nxt.busy     = 1'b1;
            st_nxt.state    = ST_READ;
          end else if (i_err_check_en) begin
            st_nxt.err     = 1'b1;
            st_nxt.err_cnt = 2'(`ERR_CYCLES - 1);
            st_nxt.busy    = 1'b0;
            st_nxt.state   = ST_ERROR;
          end
        end
      end
      ST_WRITE: begin
        if (st_r.wait_cnt > (`LAT_W+3)'(1)) begin
          st_nxt.wait_cnt = st_r.wait_cnt - (`LAT_W+3)'(1);
        end else begin
          st_nxt.strobe = 1'b1;
          if (st_r.words > `WORD_CNT_W'(1)) begin
            st_nxt.words    = st_r.words - `WORD_CNT_W'(1);
            st_nxt.wait_cnt = (`LAT_W+3)'(i_read_latency)
              + (`LAT_W+3)'(`XACT_CYCLES);
          end else begin
            st_nxt.busy  = 1'b0;
            st_nxt.state = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        if (st_r.wait_cnt > (`LAT_W+3)'(1)) begin
          st_nxt.wait_cnt = st_r.wait_cnt - (`LAT_W+3)'(1);
        end else begin
          st_nxt.rdata = i_xcvr_rdata;
          st_nxt.valid = i_read_port_en;
          st_nxt.busy  = 1'b0;
          st_nxt.state = ST_IDLE;
        end
      end
      ST_ERROR: begin
        if (st_r.err_cnt != 2'h0) begin
          st_nxt.err     = 1'b1;
          st_nxt.err_cnt = st_r.err_cnt - 2'h1;
        end else begin
          st_nxt.state = ST_IDLE;
        end
      end
      // unused state codes restart the power-up sequence
      default: begin
        st_nxt.busy  = 1'b0;
        st_nxt.state = ST_POWERUP;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r       <= '0;
      st_r.state <= ST_POWERUP;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy        = st_r.busy;
  assign o_read_valid  = st_r.valid;
  assign o_read_data   = st_r.rdata;
  assign o_error       = st_r.err;
  assign o_word_strobe = st_r.strobe;
endmodule

/* shared/reconfig_hs_defs.svh */
// constants for the reconfiguration handshake block
// assumes one free-running 50 MHz clock and no register bus
`ifndef RECONFIG_HS_DEFS_SVH
`define RECONFIG_HS_DEFS_SVH
`define CLK_MHZ          50
`define OC_TIME_US       10
`define OC_CYCLES        (`OC_TIME_US * `CLK_MHZ)
`define ERR_CYCLES       2
`define XACT_CYCLES      4
`define WORD_CNT_W       8
`define LAT_W            4
`define DATA_W           16
`define RST_LAT          4'h0
`endif

/* shared/reconfig_hs_pkg.sv */
// types for the reconfiguration handshake block
// assumes reconfig_hs_defs.svh is on the include path
package reconfig_hs_pkg;
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_OFFSET,
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_ERROR
  } hs_state_t;
endpackage

/* sim/fabric_model.sv */
// fabric request model: one-cycle pulses, only when idle
// assumes go is a one-cycle command from the bench
`timescale 1ns/100ps
module fabric_model (
  // clock, reset, status
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic o_busy,
  input  wire logic o_error,
  // bench command
  input  wire logic go,
  input  wire logic kind,
  // requests
  output logic      i_write_all = 1'b0,
  output logic      i_read = 1'b0,
  output logic      pend = 1'b0
);
  always @(posedge i_ref_clk) begin
    i_write_all <= 1'b0;
    i_read <= 1'b0;
    if (i_rst) begin
      pend <= 1'b0;
    end else if ((go || pend) && !o_busy && !o_error && !i_write_all
                 && !i_read) begin
      i_write_all <= kind;
      i_read <= !kind;
      pend <= 1'b0;
    end else if (go) begin
      pend <= 1'b1;
    end
  end
endmodule

/* sim/reconfig_hs_chk.sv */
// port checker for the reconfiguration handshake
// assumes a bind to reconfig_hs with the same OC_CYCLES
`timescale 1ns/100ps
module reconfig_hs_chk #(
  parameter int OC_CYCLES = 3
) (
  // clock, reset, configuration
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cont_write_en,
  input wire logic i_analog_mode,
  input wire logic i_analog_port_sel,
  input wire logic i_read_port_en,
  input wire logic i_err_check_en,
  // requests and status
  input wire logic i_write_all,
  input wire logic i_read,
  input wire logic o_busy,
  input wire logic o_read_valid,
  input wire logic o_error,
  input wire logic o_word_strobe
);
  localparam int OC_HI = OC_CYCLES + 2;
  logic idle;
  logic rd;
  assign idle = !o_busy && !o_error;
  assign rd = idle && i_read && !i_write_all;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // assertions
  a_power_up: assert property ($fell(i_rst) |-> !o_busy ##1 o_busy
    ##[OC_CYCLES:OC_HI] !o_busy) else $error("busy after reset wrong");
  a_wr_single: assert property (idle && i_write_all && !i_cont_write_en
    |=> o_busy [*4] ##1 (o_word_strobe && !o_busy)) else $error("write bad");
  a_cont_busy: assert property (idle && i_write_all && i_cont_write_en
    |=> o_busy [*4]) else $error("continuous write busy bad");
  a_rd_good: assert property (rd && i_analog_mode && i_analog_port_sel
    && i_read_port_en |=> o_busy [*4] ##1 (o_read_valid && !o_busy))
    else $error("read timing bad");
  a_rd_bad: assert property (rd && !(i_analog_mode && i_analog_port_sel)
    && i_err_check_en |=> o_error) else $error("bad read not flagged");
  a_rd_quiet: assert property (rd && !(i_analog_mode && i_analog_port_sel)
    && !i_err_check_en |=> idle) else $error("dropped read reacted");
  a_err_two: assert property ($rose(o_error) |-> !o_busy ##1
    (o_error && !o_busy) ##1 !o_error) else $error("error length bad");
  a_valid_gate: assert property (o_read_valid |-> i_read_port_en
    ##1 !o_read_valid) else $error("read valid bad");
  a_strobe_one: assert property (o_word_strobe |=> !o_word_strobe)
    else $error("strobe longer than a cycle");
  c_read: cover property (o_read_valid);
  c_error: cover property (o_error);
  c_cont: cover property (o_word_strobe && i_cont_write_en);
endmodule

/* sim/reconfig_hs_tb.sv */
// self-checking bench for reconfig_hs, 50 MHz clock
// assumes fabric_model and reconfig_hs_chk are compiled
`timescale 1ns/100ps
`include "reconfig_hs_defs.svh"
module reconfig_hs_tb;
  localparam int OC_CYCLES = 3;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, go = 1'b0, kind = 1'b0, pend;
  logic i_cont_write_en = 1'b0, i_analog_mode = 1'b0;
  logic i_analog_port_sel = 1'b0, i_read_port_en = 1'b0;
  logic i_err_check_en = 1'b0, i_write_all, i_read;
  logic [`LAT_W-1:0] i_read_latency = `RST_LAT;
  logic [`WORD_CNT_W-1:0] i_word_count = 8'h00;
  logic [`DATA_W-1:0] i_xcvr_rdata = 16'h0000, o_read_data, rd_seen;
  logic o_busy, o_read_valid, o_error, o_word_strobe;
  logic [15:0] n_stb, n_val, n_err, n_bsy;
  int n_fail = 0, checks = 0, t;
  always #10 i_ref_clk = !i_ref_clk;
  reconfig_hs #(.OC_CYCLES(OC_CYCLES)) u_reconfig_hs (.*);
  fabric_model u_fabric_model (.*);
  always @(posedge i_ref_clk) begin
    n_stb += o_word_strobe;
    n_val += o_read_valid;
    n_err += o_error;
    n_bsy += o_busy;
    if (o_read_valid) rd_seen = o_read_data;
  end
  function logic [15:0] n_words(bit k);
    if (!k) return 16'h0000;
    if (!i_cont_write_en || i_analog_mode || i_word_count == 8'h00)
      return 16'h0001;
    return {8'h00, i_word_count};
  endfunction
  // busy cycles: four per word, plus latency per word in continuous mode
  function logic [15:0] n_busy(bit k);
    if (!k) return (i_analog_mode && i_analog_port_sel) ? 16'h0004 : 16'h0000;
    if (i_cont_write_en && !i_analog_mode)
      return n_words(1'b1) * (16'(i_read_latency) + 16'h0004);
    return 16'h0004;
  endfunction
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // sequences
  task reset;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk("busy up", o_busy, 16'h0001);
    for (t = 0; o_busy && t < 50; t++) @(negedge i_ref_clk);
    chk("busy down", o_busy, 16'h0000);
  endtask
  task run(bit k);
    n_stb = 16'h0000;
    n_val = 16'h0000;
    n_err = 16'h0000;
    n_bsy = 16'h0000;
    @(posedge i_ref_clk);
    go <= 1'b1;
    kind <= k;
    @(posedge i_ref_clk);
    go <= 1'b0;
    t = 0;
    do begin
      @(negedge i_ref_clk);
      t++;
    end while ((pend || i_write_all || i_read || o_busy || o_error) && t < 900);
    @(negedge i_ref_clk);
    chk("strobes", n_stb, n_words(k));
    chk("busy cycles", n_bsy, n_busy(k));
    chk("errors", n_err, (!k && !(i_analog_mode && i_analog_port_sel)
        && i_err_check_en) ? 16'h0002 : 16'h0000);
    chk("valid", n_val, (!k && i_analog_mode && i_analog_port_sel
        && i_read_port_en) ? 16'h0001 : 16'h0000);
    if (n_val > 0) chk("data", rd_seen, i_xcvr_rdata);
  endtask
  // run span under 35 us, watchdog at 500 us
  initial begin
    #500000;
    n_fail++;
    summarize;
  end
  initial begin
    void'($urandom(32'h11B4));
    reset;
    for (int i = 0; i < 40; i++) begin
      @(posedge i_ref_clk);
      {i_cont_write_en, i_analog_mode, i_analog_port_sel, i_read_port_en,
       i_err_check_en} <= (i == 0) ? 5'h1B : 5'($urandom);
      i_read_latency <= 4'($urandom_range(3));
      i_word_count <= (i == 0) ? 8'h00 : 8'($urandom_range(5));
      i_xcvr_rdata <= 16'($urandom);
      run(i == 0 || 1'($urandom));
      if (i == 20) reset;
    end
    summarize;
  end
endmodule
bind reconfig_hs reconfig_hs_chk #(.OC_CYCLES(OC_CYCLES)) u_reconfig_hs_chk (.*);
